/* File: awc_pkg.sv */
package awc_pkg;
    // tag, window and data widths
    localparam int SEQ_W = 6;
    localparam int WIN_DEF = 8;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 32;
    // timing: one tick is a microsecond
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = 6;
    localparam int TMR_W = 10;
    localparam int RTRY_W = 4;
    // retry timeout, idle ack and flush timeout in ticks, and retry limit as a count of retries
    localparam int RTO_TICKS = 200;
    localparam int MAX_RETRY = 3;
    localparam int ACK_IVL_TICKS = 500;
    localparam int FLUSH_TICKS = 300;
endpackage : awc_pkg

/* File: awc_mem.sv */
module awc_mem #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [$clog2(D)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(D)-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [D];

    // write port and registered read port
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : awc_mem

/* File: awc_fifo.sv */
module awc_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } awc_fifo_s;
    awc_fifo_s s_q, s_d;
    logic [W-1:0] mem [D];
    logic push, pop;

    if (D < 2 || (1 << AW) != D) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    assign in_ready = s_q.cnt != (AW + 1)'(D);
    assign out_valid = s_q.cnt != '0;
    assign out_data = mem[s_q.rp];
    assign count = s_q.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and fill bookkeeping
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem[s_q.wp] <= in_data;
        end
    end
endmodule : awc_fifo

/* File: awc_window_control.sv */
// Operation
// [R1] in-order packet with payload is accepted and delivered in sequence
// [R2] in-order packet without payload is dropped after inspection
// [R3] early in-window packet marks all skipped identifiers as lost
// [R4] early payload is held and delivered once all earlier ones are out
// [R5] packet outside the input window is ignored
// [R6] first negative ack frees every earlier packet from the transmit window
// [R7] with no negative ack, positive ack frees every earlier packet
// [R8] every negatively acknowledged packet is queued for retransmission
// [R9] flush bit on full window, upper layer request or flush timeout
// [R10] receiver returns an ack whenever a packet carries the flush bit
// [R11] advertised window field in acks gives receiver flow control
// [R12] receiver may send unsolicited acks after an idle interval
// [R13] each unacknowledged packet has its own retry timer
// [R14] timer and negative-ack retransmissions work independently
// [R15] connection is released after the retry limit is exceeded
// [R16] identifier comparisons use modular sequence arithmetic
module awc_window_control import awc_pkg::*; #(
    parameter int SW = SEQ_W,
    parameter int WIN = WIN_DEF,
    parameter int DW = DATA_W,
    parameter int FD = FIFO_DEPTH,
    parameter int RTO = RTO_TICKS,
    parameter int MAXR = MAX_RETRY,
    parameter int ACK_IVL = ACK_IVL_TICKS,
    parameter int FLUSH_TO = FLUSH_TICKS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [SW-1:0] rx_tag,
    input wire logic rx_has_data,
    input wire logic rx_flush,
    input wire logic [DW-1:0] rx_data,
    output logic convergence_layer_valid,
    input wire logic convergence_layer_ready,
    output logic [DW-1:0] convergence_layer_data,
    output logic ack_valid,
    output logic [SW-1:0] ack_tag,
    output logic [WIN-1:0] ack_lost,
    output logic [SW-1:0] ack_win,
    input wire logic tx_new_valid,
    output logic tx_new_ready,
    output logic [SW-1:0] tx_tag,
    output logic tx_flush,
    input wire logic convergence_layer_flush_req,
    input wire logic ain_valid,
    input wire logic ain_nack,
    input wire logic ain_last,
    input wire logic [SW-1:0] ain_tag,
    input wire logic [SW-1:0] ain_win,
    output logic retx_valid,
    input wire logic retx_ready,
    output logic [SW-1:0] retx_tag,
    output logic conn_release
);
    localparam int LW = $clog2(WIN);
    localparam int CW = $clog2(FD) + 1;
    localparam logic [SW-1:0] WIN_S = SW'(WIN);

    if (WIN < 2 || (1 << LW) != WIN || 2 * WIN > (1 << SW) || WIN > FD
        || RTO < 2 || RTO >= (1 << TMR_W) || ACK_IVL < 1 || ACK_IVL >= (1 << TMR_W)
        || FLUSH_TO < 1 || FLUSH_TO >= (1 << TMR_W) || MAXR >= (1 << RTRY_W))
    begin : g_chk
        $error("window or timer parameters out of range");
    end

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [SW-1:0] exp;
        logic [WIN-1:0] held;
        logic [WIN-1:0] lost;
        logic drain;
        logic ack;
        logic [SW-1:0] ack_tag;
        logic [WIN-1:0] ack_map;
        logic [SW-1:0] ack_win;
        logic [TMR_W-1:0] ack_tmr;
        logic [SW-1:0] tx_base;
        logic [SW-1:0] tx_next;
        logic [SW-1:0] peer_win;
        logic nack_seen;
        logic [WIN-1:0] retx;
        logic [WIN-1:0][TMR_W-1:0] tmr;
        logic [WIN-1:0][RTRY_W-1:0] rtry;
        logic [TMR_W-1:0] flush_tmr;
        logic flush_to;
        logic rel;
    } awc_st_s;
    awc_st_s s_q, s_d;

    logic [SW-1:0] rx_off, tx_out, a_off;
    logic [LW-1:0] exp_slot, a_slot;
    logic rx_take, in_order, in_win, drain_go, push_v, mem_we, fifo_ready;
    logic own_full, peer_full, fill_now, a_fits, tx_take, retx_take;
    logic [DW-1:0] push_data, mem_rd;
    logic [CW-1:0] fifo_cnt;
    logic [LW:0] pick;

    // lowest-offset pending retransmission, walking from the window base
    function automatic logic [LW:0] first_retx(input logic [WIN-1:0] r,
                                               input logic [LW-1:0] b);
        logic [LW-1:0] slot;
        first_retx = '0;
        for (int k = WIN - 1; k >= 0; k--) begin
            slot = b + LW'(k);
            if (r[slot]) begin
                first_retx = {1'b1, LW'(k)};
            end
        end
    endfunction : first_retx

    // receive side decode, all offsets modulo the tag space
    assign rx_off = rx_tag - s_q.exp; // [R16]
    assign in_order = rx_off == '0;
    assign in_win = rx_off < WIN_S; // [R5]
    assign exp_slot = s_q.exp[LW-1:0];
    assign drain_go = s_q.held[exp_slot] && !s_q.drain && fifo_ready; // [R4]
    assign rx_ready = !drain_go && !s_q.drain && fifo_ready;
    assign rx_take = rx_valid && rx_ready;
    assign push_v = s_q.drain || (rx_take && in_order && rx_has_data); // [R1] [R2]
    assign push_data = s_q.drain ? mem_rd : rx_data;
    assign mem_we = rx_take && in_win && !in_order && rx_has_data; // [R4]

    // transmit side decode
    assign tx_out = s_q.tx_next - s_q.tx_base; // [R16]
    assign own_full = tx_out == WIN_S;
    assign peer_full = tx_out >= s_q.peer_win;
    assign fill_now = (tx_out + 1'b1 == WIN_S) || (tx_out + 1'b1 >= s_q.peer_win);
    assign tx_new_ready = !own_full && !peer_full;
    assign tx_take = tx_new_valid && tx_new_ready;
    assign tx_tag = s_q.tx_next;
    assign tx_flush = fill_now || convergence_layer_flush_req || s_q.flush_to; // [R9]
    assign a_off = ain_tag - s_q.tx_base; // [R16]
    assign a_fits = a_off <= tx_out;
    assign a_slot = ain_tag[LW-1:0];
    assign pick = first_retx(s_q.retx, s_q.tx_base[LW-1:0]);
    assign retx_valid = pick[LW];
    assign retx_tag = s_q.tx_base + SW'(pick[LW-1:0]);
    assign retx_take = retx_valid && retx_ready;

    // registered outputs
    assign ack_valid = s_q.ack;
    assign ack_tag = s_q.ack_tag;
    assign ack_lost = s_q.ack_map;
    assign ack_win = s_q.ack_win;
    assign conn_release = s_q.rel;

    // next-state logic for both directions
    always_comb begin
        logic [WIN-1:0] expire;
        logic [LW-1:0] o;
        logic [LW-1:0] sl;
        logic [SW-1:0] outn;
        logic [CW-1:0] free;
        expire = '0;
        o = '0;
        sl = '0;
        outn = '0;
        free = '0;
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.ack = 1'b0;
        s_d.rel = 1'b0;
        // microsecond tick
        if (s_q.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 1'b1;
        end
        // held payload reaches the upper layer in sequence
        if (s_q.drain) begin
            s_d.held[exp_slot] = 1'b0; // [R4]
            s_d.lost[exp_slot] = 1'b0;
            s_d.exp = s_q.exp + 1'b1;
        end
        s_d.drain = drain_go;
        if (rx_take && in_order && rx_has_data) begin
            s_d.lost[exp_slot] = 1'b0; // [R1]
            s_d.exp = s_q.exp + 1'b1;
        end else if (rx_take && !in_order && in_win) begin
            for (int i = 0; i < WIN; i++) begin
                o = LW'(i) - exp_slot;
                if (o < rx_off[LW-1:0] && !s_q.held[i]) begin
                    s_d.lost[i] = 1'b1; // [R3]
                end
            end
            if (rx_has_data) begin
                s_d.held[rx_tag[LW-1:0]] = 1'b1; // [R4]
                s_d.lost[rx_tag[LW-1:0]] = 1'b0;
            end
        end
        // ack on flush bit, or after an idle interval
        if (s_q.tick) begin
            s_d.ack_tmr = s_q.ack_tmr + 1'b1;
        end
        if ((rx_take && rx_flush) // [R10]
            || (s_q.tick && s_q.ack_tmr == TMR_W'(ACK_IVL - 1))) begin // [R12]
            s_d.ack = 1'b1;
            s_d.ack_tmr = '0;
            s_d.ack_tag = s_d.exp;
            for (int k = 0; k < WIN; k++) begin
                sl = s_d.exp[LW-1:0] + LW'(k);
                s_d.ack_map[k] = s_d.lost[sl] && !s_d.held[sl];
            end
            free = CW'(FD) - fifo_cnt;
            s_d.ack_win = (free >= CW'(WIN)) ? WIN_S : SW'(free); // [R11]
        end
        // per-packet retry timers
        for (int i = 0; i < WIN; i++) begin
            o = LW'(i) - s_q.tx_base[LW-1:0];
            if (SW'(o) < tx_out && s_q.tick && s_q.tmr[i] != '0) begin
                s_d.tmr[i] = s_q.tmr[i] - 1'b1; // [R13]
                if (s_q.tmr[i] == TMR_W'(1)) begin
                    if (s_q.rtry[i] == RTRY_W'(MAXR)) begin
                        s_d.rel = 1'b1; // [R15]
                    end else begin
                        expire[i] = 1'b1;
                        s_d.rtry[i] = s_q.rtry[i] + 1'b1;
                    end
                end
            end
        end
        if (retx_take) begin
            s_d.retx[retx_tag[LW-1:0]] = 1'b0;
            s_d.tmr[retx_tag[LW-1:0]] = TMR_W'(RTO);
        end
        s_d.retx = s_d.retx | expire; // [R14]
        // acknowledgement message from the peer receiver
        if (ain_valid) begin
            if (!s_q.nack_seen && a_fits) begin
                s_d.tx_base = ain_tag; // [R6] [R7]
            end
            if (ain_nack && a_off < tx_out) begin
                s_d.retx[a_slot] = 1'b1; // [R8]
            end
            if (!ain_nack) begin
                s_d.peer_win = ain_win;
            end
            s_d.nack_seen = !ain_last && (s_q.nack_seen || ain_nack);
        end
        // new packet enters the transmit window
        if (tx_take) begin
            s_d.tx_next = s_q.tx_next + 1'b1;
            s_d.tmr[s_q.tx_next[LW-1:0]] = TMR_W'(RTO);
            s_d.rtry[s_q.tx_next[LW-1:0]] = '0;
            s_d.retx[s_q.tx_next[LW-1:0]] = 1'b0;
        end
        // flush timeout while packets are outstanding
        if (tx_take && tx_flush) begin
            s_d.flush_tmr = '0;
            s_d.flush_to = 1'b0;
        end else if (s_q.tick && tx_out != '0) begin
            if (s_q.flush_tmr == TMR_W'(FLUSH_TO - 1)) begin
                s_d.flush_to = 1'b1; // [R9]
            end else begin
                s_d.flush_tmr = s_q.flush_tmr + 1'b1;
            end
        end
        // freed slots drop pending retransmissions
        outn = s_d.tx_next - s_d.tx_base;
        for (int i = 0; i < WIN; i++) begin
            o = LW'(i) - s_d.tx_base[LW-1:0];
            if (SW'(o) >= outn) begin
                s_d.retx[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.peer_win <= WIN_S;
        end else begin
            s_q <= s_d;
        end
    end

    awc_mem #(.W(DW), .D(WIN)) u_hold (
        .clk_sys(clk_sys),
        .we(mem_we),
        .waddr(rx_tag[LW-1:0]),
        .wdata(rx_data),
        .raddr(exp_slot),
        .rdata(mem_rd)
    );

    awc_fifo #(.W(DW), .D(FD)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(push_v),
        .in_ready(fifo_ready),
        .in_data(push_data),
        .out_valid(convergence_layer_valid),
        .out_ready(convergence_layer_ready),
        .out_data(convergence_layer_data),
        .count(fifo_cnt)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    in_order_take_a: assert property (rx_take && in_order && rx_has_data // [R1]
        |-> push_v ##1 (s_q.exp - $past(rx_tag)) == SW'(1))
        else $error("in-order packet not delivered");
    empty_drop_a: assert property (rx_take && in_order && !rx_has_data // [R2]
        |-> !push_v ##1 $stable(s_q.exp))
        else $error("empty packet changed receive state");
    gap_lost_a: assert property (rx_take && !in_order && in_win // [R3]
        |=> s_q.lost[$past(exp_slot)])
        else $error("skipped packet not marked lost");
    early_hold_a: assert property (mem_we // [R4]
        |=> s_q.held[$past(rx_tag[LW-1:0])] && !s_q.lost[$past(rx_tag[LW-1:0])])
        else $error("early payload not held");
    outside_drop_a: assert property (rx_take && !in_win // [R5]
        |=> $stable(s_q.held) && $stable(s_q.exp))
        else $error("out-of-window packet altered state");
    nack_free_a: assert property (ain_valid && ain_nack && !s_q.nack_seen && a_fits // [R6]
        |=> s_q.tx_base == $past(ain_tag))
        else $error("first negative ack did not free window");
    ack_free_a: assert property (ain_valid && !ain_nack && !s_q.nack_seen && a_fits // [R7]
        |=> s_q.tx_base == $past(ain_tag))
        else $error("positive ack did not free window");
    nack_retx_a: assert property (ain_valid && ain_nack && a_off < tx_out // [R8]
        |=> retx_valid)
        else $error("negative ack not queued for resend");
    fill_flush_a: assert property ($rose(own_full) |-> $past(tx_flush)) // [R9]
        else $error("window filled without flush bit");
    flush_ack_a: assert property (rx_take && rx_flush |=> ack_valid // [R10]
        && ack_tag == s_q.exp)
        else $error("flush bit not acknowledged");
endmodule : awc_window_control

/* File: awc_peer.sv */
module awc_peer import awc_pkg::*; (
    input wire logic clk_sys,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [SEQ_W-1:0] rx_tag,
    output logic rx_has_data,
    output logic rx_flush,
    output logic [DATA_W-1:0] rx_data,
    input wire logic convergence_layer_valid,
    output logic convergence_layer_ready,
    input wire logic [DATA_W-1:0] convergence_layer_data,
    input wire logic ack_valid,
    input wire logic [SEQ_W-1:0] ack_tag,
    input wire logic [WIN_DEF-1:0] ack_lost,
    input wire logic [SEQ_W-1:0] ack_win,
    input wire logic retx_valid,
    output logic retx_ready,
    input wire logic [SEQ_W-1:0] retx_tag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stall = 1'h0;
    logic [DATA_W-1:0] got[$];
    logic [SEQ_W-1:0] rtx[$];
    int acks = 0;
    logic [SEQ_W-1:0] a_tag = '0;
    logic [WIN_DEF-1:0] a_lost = '0;
    logic [SEQ_W-1:0] a_win = '0;
    // idle levels at time zero
    initial begin
        rx_valid = 1'h0;
        rx_tag = '0;
        rx_has_data = 1'h0;
        rx_flush = 1'h0;
        rx_data = '0;
        convergence_layer_ready = 1'h1;
        retx_ready = 1'h1;
    end
    // upper layer sink follows the stall switch
    always @(posedge clk_sys) begin
        convergence_layer_ready <= ~stall;
    end
    // record words, acks and resends where outputs are settled
    always @(negedge clk_sys) begin
        if (convergence_layer_valid === 1'h1 && convergence_layer_ready === 1'h1)
            got.push_back(convergence_layer_data);
        if (retx_valid === 1'h1 && retx_ready === 1'h1) rtx.push_back(retx_tag);
        if (ack_valid === 1'h1) begin
            acks++;
            a_tag = ack_tag;
            a_lost = ack_lost;
            a_win = ack_win;
        end
    end
    // one packet, held until taken, then valid dropped and tag and data inverted
    task automatic send(input logic [SEQ_W-1:0] t, input logic d, input logic f,
                        input logic [DATA_W-1:0] w);
        int n = 0;
        @(posedge clk_sys);
        rx_valid <= 1'h1;
        rx_tag <= t;
        rx_has_data <= d;
        rx_flush <= f;
        rx_data <= w;
        @(negedge clk_sys);
        while (rx_ready !== 1'h1 && n < 3000) begin
            n++;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        rx_valid <= 1'h0;
        rx_tag <= ~t;
        rx_data <= ~w;
    endtask : send
endmodule : awc_peer

/* File: tb.sv */
module tb import awc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic rx_valid, rx_ready, rx_has_data, rx_flush, ack_valid;
    logic convergence_layer_valid, convergence_layer_ready;
    logic tx_new_ready, tx_flush, retx_valid, retx_ready, conn_release;
    logic [SEQ_W-1:0] rx_tag, ack_tag, ack_win, tx_tag, retx_tag;
    logic [DATA_W-1:0] rx_data, convergence_layer_data;
    logic [WIN_DEF-1:0] ack_lost;
    logic tx_new_valid = 1'h0, convergence_layer_flush_req = 1'h0;
    logic ain_valid = 1'h0, ain_nack = 1'h0, ain_last = 1'h0;
    logic [SEQ_W-1:0] ain_tag = '0;
    logic [SEQ_W-1:0] ain_win = 6'h08;
    int mismatches = 0, compares = 0, cycles = 0, rels = 0;
    logic [SEQ_W-1:0] nx = '0;
    logic [DATA_W-1:0] nd = 32'h0000_0100;
    logic [DATA_W-1:0] expq[$];

    awc_window_control #(.RTO(2), .MAXR(1), .ACK_IVL(20), .FLUSH_TO(2)) i_awc_window_control (
        .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_tag(rx_tag), .rx_has_data(rx_has_data), .rx_flush(rx_flush), .rx_data(rx_data),
        .convergence_layer_valid(convergence_layer_valid),
        .convergence_layer_ready(convergence_layer_ready),
        .convergence_layer_data(convergence_layer_data), .ack_valid(ack_valid),
        .ack_tag(ack_tag), .ack_lost(ack_lost), .ack_win(ack_win),
        .tx_new_valid(tx_new_valid), .tx_new_ready(tx_new_ready), .tx_tag(tx_tag),
        .tx_flush(tx_flush), .convergence_layer_flush_req(convergence_layer_flush_req),
        .ain_valid(ain_valid),
        .ain_nack(ain_nack), .ain_last(ain_last), .ain_tag(ain_tag), .ain_win(ain_win),
        .retx_valid(retx_valid), .retx_ready(retx_ready), .retx_tag(retx_tag),
        .conn_release(conn_release));
    awc_peer i_awc_peer (
        .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_tag(rx_tag),
        .rx_has_data(rx_has_data), .rx_flush(rx_flush), .rx_data(rx_data),
        .convergence_layer_valid(convergence_layer_valid),
        .convergence_layer_ready(convergence_layer_ready),
        .convergence_layer_data(convergence_layer_data), .ack_valid(ack_valid),
        .ack_tag(ack_tag), .ack_lost(ack_lost), .ack_win(ack_win), .retx_valid(retx_valid),
        .retx_ready(retx_ready), .retx_tag(retx_tag));

    // clock, watchdog and release pulse count
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    always @(negedge clk_sys) begin
        if (conn_release === 1'h1) rels++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic pkt(input logic [SEQ_W-1:0] t, input logic d, input logic f);
        i_awc_peer.send(t, d, f, nd);
        nd++;
    endtask : pkt
    // next in-order packet, its word expected upstream
    task automatic ino(input logic d, input logic f);
        if (d) expq.push_back(nd);
        pkt(nx, d, f);
        if (d) nx++;
    endtask : ino
    task automatic drain();
        int n = 0;
        while (i_awc_peer.got.size() < expq.size() && n < 3000) begin
            n++;
            @(posedge clk_sys);
        end
        cyc(3);
        check("delivered count", i_awc_peer.got.size(), expq.size());
        foreach (expq[i])
            if (i < i_awc_peer.got.size()) check("word", i_awc_peer.got[i], expq[i]);
        expq.delete();
        i_awc_peer.got.delete();
    endtask : drain
    task automatic txn(output logic [SEQ_W-1:0] t, output logic f);
        int n = 0;
        @(posedge clk_sys);
        tx_new_valid <= 1'h1;
        @(negedge clk_sys);
        while (tx_new_ready !== 1'h1 && n < 500) begin
            n++;
            @(negedge clk_sys);
        end
        check("tx room", tx_new_ready, 1);
        t = tx_tag;
        f = tx_flush;
        @(posedge clk_sys);
        tx_new_valid <= 1'h0;
    endtask : txn
    task automatic beat(input logic k, input logic l, input logic [SEQ_W-1:0] t);
        @(posedge clk_sys);
        ain_valid <= 1'h1;
        ain_nack <= k;
        ain_last <= l;
        ain_tag <= t;
    endtask : beat
    // ack message: optional nack entry, then the closing ack entry
    task automatic amsg(input logic nk, input logic [SEQ_W-1:0] tn, input logic [SEQ_W-1:0] ta);
        if (nk) beat(1'h1, 1'h0, tn);
        beat(1'h0, 1'h1, ta);
        @(posedge clk_sys);
        ain_valid <= 1'h0;
        ain_tag <= ~ta;
    endtask : amsg
    task automatic fill8(input logic [SEQ_W-1:0] b);
        logic [SEQ_W-1:0] t;
        logic f;
        for (int i = 0; i < 8; i++) begin
            txn(t, f);
            check("tx tag", t, SEQ_W'(b + i));
            if (i == 0) check("flush early", f, 0);
            if (i == 7) check("flush full", f, 1);
        end
        @(negedge clk_sys);
        check("window full", tx_new_ready, 0);
    endtask : fill8

    task automatic t_inorder();
        int a0 = i_awc_peer.acks;
        ino(1, 1);
        cyc(3);
        check("ack sent", i_awc_peer.acks > a0, 1);
        check("ack tag", i_awc_peer.a_tag, nx);
        check("ack window", i_awc_peer.a_win, 8);
        ino(0, 1);
        cyc(3);
        check("empty kept tag", i_awc_peer.a_tag, nx);
        drain();
    endtask : t_inorder
    task automatic t_early();
        logic [SEQ_W-1:0] e = nx;
        logic [DATA_W-1:0] w = nd;
        int a0 = i_awc_peer.acks;
        pkt(e + 6'h02, 1, 1);
        cyc(3);
        check("ack sent", i_awc_peer.acks > a0, 1);
        check("ack tag", i_awc_peer.a_tag, e);
        check("lost map", i_awc_peer.a_lost, 8'h03);
        ino(1, 0);
        ino(1, 0);
        expq.push_back(w);
        nx++;
        drain();
    endtask : t_early
    task automatic t_outside();
        pkt(nx + 6'h20, 1, 0);
        ino(1, 1);
        cyc(3);
        check("ack tag", i_awc_peer.a_tag, nx);
        drain();
    endtask : t_outside
    task automatic t_fill();
        i_awc_peer.stall = 1'h1;
        cyc(2);
        repeat (32) ino(1, 0);
        cyc(3);
        @(negedge clk_sys);
        check("fifo refuses", rx_ready, 0);
        i_awc_peer.stall = 1'h0;
        repeat (32) ino(1, 0);
        drain();
    endtask : t_fill
    task automatic t_window();
        int n = 0;
        fill8(6'h00);
        amsg(1, 6'h02, 6'h05);
        cyc(2);
        @(negedge clk_sys);
        check("room after nack", tx_new_ready, 1);
        while (i_awc_peer.rtx.size() == 0 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        check("resend tag", i_awc_peer.rtx.size() > 0 ? i_awc_peer.rtx[0] : 6'h3F, 2);
        amsg(0, 6'h00, 6'h08);
        fill8(6'h08);
        amsg(0, 6'h00, 6'h10);
    endtask : t_window
    task automatic t_upflush();
        @(posedge clk_sys);
        convergence_layer_flush_req <= 1'h1;
        @(negedge clk_sys);
        check("flush on request", tx_flush, 1);
        @(posedge clk_sys);
        convergence_layer_flush_req <= 1'h0;
        @(negedge clk_sys);
        check("flush dropped", tx_flush, 0);
        // peer advertises a one-packet window: next packet fills it
        @(posedge clk_sys);
        ain_win <= 6'h01;
        amsg(0, 6'h00, 6'h10);
        @(negedge clk_sys);
        check("flush peer full", tx_flush, 1);
        @(posedge clk_sys);
        ain_win <= 6'h08;
        amsg(0, 6'h00, 6'h10);
    endtask : t_upflush
    task automatic t_timer();
        logic [SEQ_W-1:0] t;
        logic f;
        int n = 0;
        cyc(5);
        i_awc_peer.rtx.delete();
        txn(t, f);
        check("tx tag", t, 16);
        while (i_awc_peer.rtx.size() == 0 && n < 600) begin
            n++;
            @(posedge clk_sys);
        end
        check("timer resend", i_awc_peer.rtx.size() > 0 ? i_awc_peer.rtx[0] : 6'h3F, 16);
        cyc(60);
        @(negedge clk_sys);
        check("flush timeout", tx_flush, 1);
        n = 0;
        while (rels == 0 && n < 600) begin
            n++;
            @(posedge clk_sys);
        end
        check("released", rels > 0, 1);
        amsg(0, 6'h00, 6'h11);
    endtask : t_timer
    task automatic t_idle();
        int a0 = i_awc_peer.acks;
        cyc(1300);
        check("unsolicited ack", i_awc_peer.acks > a0, 1);
    endtask : t_idle

    initial begin
        cyc(4);
        rst_n <= 1'h1;
        @(negedge clk_sys);
        check("rx ready", rx_ready, 1);
        check("tx ready", tx_new_ready, 1);
        check("tx tag", tx_tag, 0);
        check("no release", conn_release, 0);
        t_inorder();
        t_early();
        t_outside();
        t_fill();
        t_window();
        t_upflush();
        t_timer();
        t_idle();
        final_report();
    end
endmodule : tb
